// >>> src/tmc_filter.sv
`timescale 1ns/1ps
`include "tmc_map.svh"
module tmc_filter #(
    parameter int SAMPLES = `TMC_FILTER_SAMPLES
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Sample stream
    input wire logic pin_in,
    output logic level_out
);
    // Pin itself is the newest sample, so the lag is SAMPLES clocks
    logic [SAMPLES-2:0] hist_reg;
    logic [SAMPLES-2:0] hist_next;
    logic [SAMPLES-1:0] window;
    logic level_reg;
    logic level_next;
    always_comb
    begin
        window = {hist_reg, pin_in};
        hist_next = window[SAMPLES-2:0];
        level_next = level_reg;
        if (&window)
            level_next = 1'b1;
        else if (~|window)
            level_next = 1'b0;
    end
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            hist_reg <= '0;
            level_reg <= 1'b0;
        end
        else
        begin
            hist_reg <= hist_next;
            level_reg <= level_next;
        end
    end
    assign level_out = level_reg;
endmodule : tmc_filter

// >>> src/tmc_map.svh
`ifndef TMC_MAP_SVH
`define TMC_MAP_SVH
`define TMC_OFS_CTRL_A 8'h90
`define TMC_OFS_CTRL_B 8'h91
`define TMC_OFS_CAPTURE 8'h96
`define TMC_OFS_COMPARE_A 8'h98
`define TMC_OFS_COUNT 8'h94
`define TMC_OFS_STATUS 8'hA0
`define TMC_OFS_MASK 8'hA4
`define TMC_ADDR_OF(idx) ((idx) << 2)
`define TMC_CTRL_B_RESET 8'h00
`define TMC_B_FILTER_BIT 7
`define TMC_B_EDGE_BIT 6
`define TMC_B_MODE_HI 4
`define TMC_B_MODE_LO 3
`define TMC_B_CS_HI 2
`define TMC_FILTER_SAMPLES 4
`define TMC_TOP_MAX 16'hFFFF
`define TMC_TOP_8BIT 16'h00FF
`define TMC_TOP_9BIT 16'h01FF
`define TMC_TOP_10BIT 16'h03FF
`define TMC_ST_CAPTURE 0
`define TMC_ST_OVERFLOW 1
`endif

// >>> src/tmc_mode_dec.sv
`timescale 1ns/1ps
`include "tmc_map.svh"
module tmc_mode_dec
    import tmc_pkg::*;
(
    tmc_mode_if.decoder mif
);
    always_comb
    begin
        mif.kind = TMC_NORMAL;
        mif.top_src = TMC_TOP_FIXED;
        mif.update_at = TMC_AT_IMMEDIATE;
        mif.ovf_at = TMC_AT_TOP;
        mif.fixed_top = `TMC_TOP_MAX;
        mif.dual_slope = 1'b0;
        mif.reserved = 1'b0;
        case (mif.mode)
            4'h0: mif.fixed_top = `TMC_TOP_MAX;
            4'h4:
            begin
                mif.kind = TMC_CTC;
                mif.top_src = TMC_TOP_CMP_A;
            end
            4'hC:
            begin
                mif.kind = TMC_CTC;
                mif.top_src = TMC_TOP_CAPT;
            end
            4'hD: mif.reserved = 1'b1;
            4'h1, 4'h2, 4'h3, 4'hA, 4'hB:
            begin
                mif.kind = TMC_PWM_PC;
                mif.update_at = TMC_AT_TOP;
                mif.ovf_at = TMC_AT_BOTTOM;
                mif.dual_slope = 1'b1;
                mif.fixed_top = (mif.mode == 4'h1) ? `TMC_TOP_8BIT :
                    (mif.mode == 4'h2) ? `TMC_TOP_9BIT : `TMC_TOP_10BIT;
                if (mif.mode == 4'hA)
                    mif.top_src = TMC_TOP_CAPT;
                else if (mif.mode == 4'hB)
                    mif.top_src = TMC_TOP_CMP_A;
            end
            4'h5, 4'h6, 4'h7, 4'hE, 4'hF:
            begin
                mif.kind = TMC_PWM_FAST;
                mif.update_at = TMC_AT_BOTTOM;
                mif.ovf_at = TMC_AT_TOP;
                mif.fixed_top = (mif.mode == 4'h5) ? `TMC_TOP_8BIT :
                    (mif.mode == 4'h6) ? `TMC_TOP_9BIT : `TMC_TOP_10BIT;
                if (mif.mode == 4'hE)
                    mif.top_src = TMC_TOP_CAPT;
                else if (mif.mode == 4'hF)
                    mif.top_src = TMC_TOP_CMP_A;
            end
            4'h8, 4'h9:
            begin
                mif.kind = TMC_PWM_PC;
                mif.update_at = TMC_AT_BOTTOM;
                mif.ovf_at = TMC_AT_BOTTOM;
                mif.dual_slope = 1'b1;
                mif.top_src = (mif.mode == 4'h8) ? TMC_TOP_CAPT : TMC_TOP_CMP_A;
            end
            default: mif.reserved = 1'b1;
        endcase
    end
endmodule : tmc_mode_dec

// >>> src/tmc_mode_if.sv
`timescale 1ns/1ps
interface tmc_mode_if;
    import tmc_pkg::*;
    logic [3:0] mode;
    tmc_kind_t kind;
    tmc_top_src_t top_src;
    tmc_event_t update_at;
    tmc_event_t ovf_at;
    logic [15:0] fixed_top;
    logic dual_slope;
    logic reserved;
    modport decoder (input mode, output kind, top_src, update_at, ovf_at, fixed_top,
        dual_slope, reserved);
    modport user (output mode, input kind, top_src, update_at, ovf_at, fixed_top,
        dual_slope, reserved);
endinterface : tmc_mode_if

// >>> src/tmc_pkg.sv
package tmc_pkg;
    typedef enum logic [3:0] {
        TMC_NORMAL = 4'h1,
        TMC_CTC = 4'h2,
        TMC_PWM_PC = 4'h4,
        TMC_PWM_FAST = 4'h8
    } tmc_kind_t;
    typedef enum logic [2:0] {
        TMC_TOP_FIXED = 3'h1,
        TMC_TOP_CMP_A = 3'h2,
        TMC_TOP_CAPT = 3'h4
    } tmc_top_src_t;
    typedef enum logic [2:0] {
        TMC_AT_IMMEDIATE = 3'h1,
        TMC_AT_TOP = 3'h2,
        TMC_AT_BOTTOM = 3'h4
    } tmc_event_t;
    typedef enum logic [1:0] {
        TMC_UP = 2'h1,
        TMC_DOWN = 2'h2
    } tmc_dir_t;
endpackage : tmc_pkg

// >>> src/tmc_timer.sv
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "tmc_map.svh"
// Function
// - Mode 0 normal, 4/12 clear-on-match, immediate update, overflow at MAX, 13 reserved
// - Modes 1-3,10,11 phase-correct; update at TOP, overflow at BOTTOM
// - Modes 5-7,14,15 fast PWM; update at BOTTOM, overflow at TOP
// - Filter output changes after four equal consecutive pin samples
// - Filtered capture lags unfiltered path by four clocks
// - Edge select zero means falling edge, one means rising
// - Capture copies counter and sets flag; interrupt only if enabled
// - Capture disabled while capture register is TOP
// - Clock select 000 stops the counter
// - Selects 001-101 give divide by 1, 8, 64, 256, 1024
// - Control B: filter 7, edge 6, mode 4:3, clock select 2:0
// - Selects 110/111 count external pin falling/rising edges
// - Mode joins two bits of control A with two of control B
module tmc_timer
    import tmc_pkg::*;
#(
    parameter int PRESCALE_W = 10
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Pins
    input wire logic capture_pin_in,
    input wire logic ext_clock_pin_in,
    // Interrupt and status
    output logic irq_out,
    output logic [15:0] count_out
);
    tmc_mode_if mif();
    logic [7:0] ctrl_a_reg, ctrl_a_next;
    logic [7:0] ctrl_b_reg, ctrl_b_next;
    logic [15:0] count_reg, count_next;
    logic [15:0] capture_reg, capture_next;
    logic [15:0] cmp_a_reg, cmp_a_next;
    logic [15:0] cmp_a_buf_reg, cmp_a_buf_next;
    logic [1:0] status_reg, status_next;
    logic [1:0] mask_reg, mask_next;
    tmc_dir_t dir_reg, dir_next;
    logic [PRESCALE_W-1:0] pre_reg, pre_next;
    logic ext_reg, ext_next;
    logic cap_prev_reg, cap_prev_next;
    logic [31:0] rdata_reg, rdata_next;
    logic wr_pend_reg, wr_pend_next;
    logic [7:0] wr_idx_reg, wr_idx_next;
    logic filt_level;
    logic cap_src, cap_edge, tick, top_hit, bottom_hit;
    logic [15:0] top_val;
    logic addr_ok;
    logic [7:0] rd_idx;
    logic [2:0] cs;
    logic [1:0] st_set;
    assign mif.mode = {ctrl_b_reg[`TMC_B_MODE_HI:`TMC_B_MODE_LO], ctrl_a_reg[1:0]};
    tmc_mode_dec u_dec (
        .mif(mif)
    );
    tmc_filter #(.SAMPLES(`TMC_FILTER_SAMPLES)) u_filt (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .pin_in(capture_pin_in),
        .level_out(filt_level)
    );
    assign cs = ctrl_b_reg[`TMC_B_CS_HI:0];
    always_comb
    begin
        case (mif.top_src)
            TMC_TOP_CMP_A: top_val = cmp_a_reg;
            TMC_TOP_CAPT: top_val = capture_reg;
            default: top_val = mif.fixed_top;
        endcase
    end
    always_comb
    begin
        pre_next = (cs == 3'b000) ? '0 : PRESCALE_W'(pre_reg + 1'b1);
        ext_next = ext_clock_pin_in;
        case (cs)
            3'b001: tick = 1'b1;
            3'b010: tick = (pre_reg[2:0] == 3'h7);
            3'b011: tick = (pre_reg[5:0] == 6'h3F);
            3'b100: tick = (pre_reg[7:0] == 8'hFF);
            3'b101: tick = (pre_reg[9:0] == 10'h3FF);
            3'b110: tick = ext_reg & ~ext_clock_pin_in;
            3'b111: tick = ~ext_reg & ext_clock_pin_in;
            default: tick = 1'b0;
        endcase
    end
    assign top_hit = (count_reg == top_val);
    assign bottom_hit = (count_reg == 16'h0000);
    assign cap_src = ctrl_b_reg[`TMC_B_FILTER_BIT] ? filt_level : capture_pin_in;
    // Edge pick, off when capture is TOP
    assign cap_edge = (mif.top_src != TMC_TOP_CAPT) &&
        (ctrl_b_reg[`TMC_B_EDGE_BIT] ? (~cap_prev_reg & cap_src) : (cap_prev_reg & ~cap_src));
    // Counter and events
    always_comb
    begin
        count_next = count_reg;
        dir_next = dir_reg;
        cmp_a_next = cmp_a_reg;
        capture_next = capture_reg;
        status_next = status_reg;
        cap_prev_next = cap_src;
        st_set = 2'b00;
        if (tick && !mif.reserved)
        begin
            if (mif.dual_slope)
            begin
                if (dir_reg == TMC_UP && top_hit)
                begin
                    dir_next = TMC_DOWN;
                    count_next = 16'(count_reg - 1'b1);
                end
                else if (dir_reg == TMC_DOWN && bottom_hit)
                begin
                    dir_next = TMC_UP;
                    count_next = 16'(count_reg + 1'b1);
                end
                else
                    count_next = (dir_reg == TMC_UP) ? 16'(count_reg + 1'b1)
                        : 16'(count_reg - 1'b1);
            end
            else
            begin
                dir_next = TMC_UP;
                count_next = top_hit ? 16'h0000 : 16'(count_reg + 1'b1);
            end
            if ((mif.ovf_at == TMC_AT_TOP && top_hit && mif.kind != TMC_CTC) ||
                (mif.kind == TMC_CTC && count_reg == `TMC_TOP_MAX) ||
                (mif.ovf_at == TMC_AT_BOTTOM && bottom_hit && dir_reg == TMC_DOWN))
                st_set[`TMC_ST_OVERFLOW] = 1'b1;
            if ((mif.update_at == TMC_AT_TOP && top_hit) ||
                (mif.update_at == TMC_AT_BOTTOM && bottom_hit))
                cmp_a_next = cmp_a_buf_reg;
        end
        if (mif.update_at == TMC_AT_IMMEDIATE)
            cmp_a_next = cmp_a_buf_reg;
        if (cap_edge)
        begin
            capture_next = count_reg;
            st_set[`TMC_ST_CAPTURE] = 1'b1;
        end
        // Bus writes; set wins over clear
        if (wr_pend_reg)
        begin
            if (wr_idx_reg == `TMC_OFS_COUNT)
                count_next = hwdata_in[15:0];
            if (wr_idx_reg == `TMC_OFS_CAPTURE && !cap_edge)
                capture_next = hwdata_in[15:0];
            if (wr_idx_reg == `TMC_OFS_STATUS)
                status_next = status_reg & ~hwdata_in[1:0];
        end
        status_next = status_next | st_set;
    end
    // Register file
    assign addr_ok = (haddr_in[1:0] == 2'b00) && (haddr_in[31:10] == 22'h0);
    assign rd_idx = haddr_in[9:2];
    always_comb
    begin
        ctrl_a_next = ctrl_a_reg;
        ctrl_b_next = ctrl_b_reg;
        cmp_a_buf_next = cmp_a_buf_reg;
        mask_next = mask_reg;
        wr_pend_next = 1'b0;
        wr_idx_next = wr_idx_reg;
        rdata_next = rdata_reg;
        if (wr_pend_reg)
        begin
            case (wr_idx_reg)
                `TMC_OFS_CTRL_A: ctrl_a_next = {hwdata_in[7:4], 2'b00, hwdata_in[1:0]};
                `TMC_OFS_CTRL_B: ctrl_b_next = {hwdata_in[7:6], 1'b0, hwdata_in[4:0]};
                `TMC_OFS_COMPARE_A: cmp_a_buf_next = hwdata_in[15:0];
                `TMC_OFS_MASK: mask_next = hwdata_in[1:0];
                default: ;
            endcase
        end
        if (hsel_in && hready_in && htrans_in[1] && addr_ok)
        begin
            if (hwrite_in)
            begin
                wr_pend_next = 1'b1;
                wr_idx_next = rd_idx;
            end
            else
            begin
                case (rd_idx)
                    `TMC_OFS_CTRL_A: rdata_next = {24'h0, ctrl_a_reg};
                    `TMC_OFS_CTRL_B: rdata_next = {24'h0, ctrl_b_reg};
                    `TMC_OFS_COUNT: rdata_next = {16'h0, count_reg};
                    `TMC_OFS_CAPTURE: rdata_next = {16'h0, capture_reg};
                    `TMC_OFS_COMPARE_A: rdata_next = {16'h0, cmp_a_buf_reg};
                    `TMC_OFS_STATUS: rdata_next = {30'h0, status_reg};
                    `TMC_OFS_MASK: rdata_next = {30'h0, mask_reg};
                    default: rdata_next = 32'h0000_0000;
                endcase
            end
        end
    end
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            ctrl_a_reg <= 8'h00;
            ctrl_b_reg <= `TMC_CTRL_B_RESET;
            count_reg <= 16'h0000;
            capture_reg <= 16'h0000;
            cmp_a_reg <= 16'h0000;
            cmp_a_buf_reg <= 16'h0000;
            status_reg <= 2'b00;
            mask_reg <= 2'b00;
            dir_reg <= TMC_UP;
            pre_reg <= '0;
            ext_reg <= 1'b0;
            cap_prev_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= 8'h00;
        end
        else
        begin
            ctrl_a_reg <= ctrl_a_next;
            ctrl_b_reg <= ctrl_b_next;
            count_reg <= count_next;
            capture_reg <= capture_next;
            cmp_a_reg <= cmp_a_next;
            cmp_a_buf_reg <= cmp_a_buf_next;
            status_reg <= status_next;
            mask_reg <= mask_next;
            dir_reg <= dir_next;
            pre_reg <= pre_next;
            ext_reg <= ext_next;
            cap_prev_reg <= cap_prev_next;
            rdata_reg <= rdata_next;
            wr_pend_reg <= wr_pend_next;
            wr_idx_reg <= wr_idx_next;
        end
    end
    assign irq_out = |(status_reg & mask_reg);
    assign hrdata_out = rdata_reg;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign count_out = count_reg;
    chk_stop_holds: assert property (@(posedge clk_in) disable iff (rst_in)
        (cs == 3'b000 && !wr_pend_reg) |=> $stable(count_reg))
        else $error("counter moved with no clock");
    chk_div_eight: assert property (@(posedge clk_in) disable iff (rst_in)
        (cs == 3'b010 && tick) |=> !tick [*7])
        else $error("divide by eight ticked early");
    chk_capture_copy: assert property (@(posedge clk_in) disable iff (rst_in)
        cap_edge |=> (capture_reg == $past(count_reg) && status_reg[`TMC_ST_CAPTURE]))
        else $error("capture not recorded");
    // No capture when capture is TOP
    chk_capture_off: assert property (@(posedge clk_in) disable iff (rst_in)
        (mif.top_src == TMC_TOP_CAPT && !wr_pend_reg) |=>
        ($stable(capture_reg) && !$rose(status_reg[`TMC_ST_CAPTURE])))
        else $error("capture while used as TOP");
    // Falling edge ignored when select is one
    chk_edge_rise: assert property (@(posedge clk_in) disable iff (rst_in)
        (ctrl_b_reg[`TMC_B_EDGE_BIT] && !ctrl_b_reg[`TMC_B_FILTER_BIT] && cap_prev_reg &&
        !capture_pin_in) |=> !$rose(status_reg[`TMC_ST_CAPTURE]))
        else $error("wrong capture edge");
    sequence s_four_high;
        capture_pin_in [*4];
    endsequence
    chk_filter_four: assert property (@(posedge clk_in) disable iff (rst_in)
        s_four_high |=> filt_level)
        else $error("filter did not follow four samples");
    chk_filter_lag: assert property (@(posedge clk_in) disable iff (rst_in)
        ($rose(filt_level)) |-> $past(capture_pin_in, 4))
        else $error("filter changed without four samples");
    chk_irq_mask: assert property (@(posedge clk_in) disable iff (rst_in)
        (cap_edge && mask_reg[`TMC_ST_CAPTURE] && !wr_pend_reg) |=> irq_out)
        else $error("enabled capture gave no interrupt");
    chk_ctrl_b_reset: assert property (@(posedge clk_in)
        rst_in |=> (ctrl_b_reg == `TMC_CTRL_B_RESET))
        else $error("control B not cleared by reset");
endmodule : tmc_timer

// >>> test/tmc_timer_test.sv
`timescale 1ns/1ps
`include "tmc_map.svh"
module tmc_timer_test
    import tmc_pkg::*;
;
    localparam logic [31:0] a_ca = `TMC_ADDR_OF(`TMC_OFS_CTRL_A);
    localparam logic [31:0] a_cb = `TMC_ADDR_OF(`TMC_OFS_CTRL_B);
    localparam logic [31:0] a_cnt = `TMC_ADDR_OF(`TMC_OFS_COUNT);
    localparam logic [31:0] a_cap = `TMC_ADDR_OF(`TMC_OFS_CAPTURE);
    localparam logic [31:0] a_cmp = `TMC_ADDR_OF(`TMC_OFS_COMPARE_A);
    localparam logic [31:0] a_st = `TMC_ADDR_OF(`TMC_OFS_STATUS);
    localparam logic [31:0] a_msk = `TMC_ADDR_OF(`TMC_OFS_MASK);
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic cap_pin = 1'b0;
    logic ext_pin = 1'b0;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic irq;
    logic [15:0] count;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int seed = 35531;
    logic [31:0] rd;
    logic [15:0] a;
    logic [15:0] lag[2];
    logic [7:0] v;
    int i;
    int mx;
    int p;
    int c;
    bit dn;
    // Expected top, slope and overflow per mode; register tops are 0x30
    int dv[6] = '{0, 1, 8, 64, 256, 1024};
    int md[15] = '{1, 2, 3, 5, 6, 7, 4, 8, 9, 10, 11, 12, 13, 14, 15};
    int tp[15] = '{'h00FF, 'h01FF, 'h03FF, 'h00FF, 'h01FF, 'h03FF, 'h0030, 'h0030, 'h0030,
        'h0030, 'h0030, 'h0030, 'h0000, 'h0030, 'h0030};
    bit du[15] = '{1, 1, 1, 0, 0, 0, 0, 1, 1, 1, 1, 0, 0, 0, 0};
    bit ov[15] = '{1, 1, 1, 1, 1, 1, 0, 1, 1, 1, 1, 0, 0, 1, 1};

    always #20 clk_in = ~clk_in;

    tmc_timer #(.PRESCALE_W(10)) u_tmc_timer (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .hsel_in(hsel),
        .haddr_in(haddr),
        .htrans_in(htrans),
        .hwrite_in(hwrite),
        .hsize_in(hsize),
        .hwdata_in(hwdata),
        .hready_in(hready),
        .hrdata_out(hrdata),
        .hreadyout_out(hready),
        .hresp_out(hresp),
        .capture_pin_in(cap_pin),
        .ext_clock_pin_in(ext_pin),
        .irq_out(irq),
        .count_out(count)
    );

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // One single word transfer; waits on hready, no fixed latency assumed
    task automatic xfer(input logic wr, input logic [31:0] ad, input logic [31:0] wd);
        @(posedge clk_in);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= ad;
        hwrite <= wr;
        do @(posedge clk_in); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_in); while (hready !== 1'b1);
        rd = hrdata;
    endtask : xfer

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask : cyc

    // Long settle covers edge detect plus filter
    task automatic pin(input logic lv);
        @(posedge clk_in);
        cap_pin <= lv;
        cyc(12);
    endtask : pin

    task automatic epin(input logic lv);
        @(posedge clk_in);
        ext_pin <= lv;
        cyc(10);
    endtask : epin

    task automatic final_report;
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            errors++;
            final_report;
        end
    end

    initial
    begin
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        xfer(0, a_cb, 0);
        check("ctrl_b reset", rd, 32'h0);
        a = count;
        cyc(40);
        check("stopped", {16'h0, count}, {16'h0, a});
        for (i = 0; i < 4; i++)
        begin
            v = $random(seed);
            v[5] = 1'b0;
            v[2:0] = 3'h0;
            xfer(1, a_cb, {24'h0, v});
            xfer(0, a_cb, 0);
            check("ctrl_b rw", rd & 32'hFFFF_FFDF, {24'h0, v});
        end
        xfer(1, 32'h0000_0300, 32'hFF);
        xfer(0, 32'h0000_0300, 0);
        check("unmapped", rd, 32'h0);
        xfer(0, a_cb, 0);
        check("ctrl_b kept", rd & 32'hFFFF_FFDF, {24'h0, v});
        xfer(1, a_ca, 0);
        for (i = 1; i <= 5; i++)
        begin
            xfer(1, a_cb, i);
            cyc(2);
            a = count;
            cyc(4 * dv[i]);
            check("prescale", {16'h0, 16'(count - a)}, 32'h4);
        end
        xfer(1, a_cb, 6);
        cyc(1);
        a = count;
        epin(1);
        check("ext fall", {16'h0, 16'(count - a)}, 32'h0);
        epin(0);
        check("ext fall", {16'h0, 16'(count - a)}, 32'h1);
        xfer(1, a_cb, 7);
        cyc(1);
        a = count;
        epin(1);
        check("ext rise", {16'h0, 16'(count - a)}, 32'h1);
        epin(0);
        check("ext rise", {16'h0, 16'(count - a)}, 32'h1);
        for (i = 0; i < 15; i++)
        begin
            xfer(1, a_cb, (md[i] >> 2) << 3);
            xfer(1, a_ca, md[i] & 3);
            xfer(1, a_cmp, 32'h30);
            xfer(1, a_cap, 32'h30);
            xfer(1, a_cnt, 0);
            xfer(1, a_st, 3);
            xfer(1, a_cb, ((md[i] >> 2) << 3) | 1);
            mx = 0;
            dn = 0;
            p = count;
            repeat (2 * tp[i] + 20)
            begin
                cyc(1);
                c = count;
                if (c > mx)
                    mx = c;
                if (c == p - 1)
                    dn = 1;
                p = c;
            end
            check("top", mx, tp[i]);
            check("slope", dn, du[i]);
            xfer(1, a_cb, 0);
            xfer(0, a_st, 0);
            check("ovf flag", rd[1], ov[i]);
        end
        xfer(1, a_ca, 0);
        for (i = 0; i < 2; i++)
        begin
            xfer(1, a_cb, (i << 6) | 1);
            pin(i);
            xfer(1, a_st, 1);
            pin(!i);
            xfer(0, a_st, 0);
            check("wrong edge", rd[0], 1'b0);
            pin(i);
            xfer(0, a_st, 0);
            check("edge", rd[0], 1'b1);
        end
        xfer(1, a_msk, 1);
        cyc(1);
        check("irq on", irq, 1'b1);
        xfer(1, a_msk, 0);
        cyc(1);
        check("irq masked", irq, 1'b0);
        xfer(1, a_msk, 1);
        xfer(1, a_st, 1);
        cyc(1);
        check("irq cleared", irq, 1'b0);
        // Lag measured against the free-running count at the pin edge
        for (i = 0; i < 2; i++)
        begin
            xfer(1, a_cb, (i << 7) | 32'h41);
            pin(0);
            @(posedge clk_in);
            cap_pin <= 1'b1;
            @(negedge clk_in);
            a = count;
            cyc(12);
            xfer(0, a_cap, 0);
            lag[i] = rd[15:0] - a;
        end
        check("filter lag", {16'h0, 16'(lag[1] - lag[0])}, 32'h4);
        pin(0);
        for (i = 3; i < 5; i++)
        begin
            xfer(1, a_st, 1);
            @(posedge clk_in);
            cap_pin <= 1'b1;
            repeat (i) @(posedge clk_in);
            cap_pin <= 1'b0;
            cyc(12);
            xfer(0, a_st, 0);
            check("filter", rd[0], i == 4);
        end
        xfer(1, a_ca, 0);
        xfer(1, a_cb, 32'h58);
        xfer(1, a_st, 1);
        pin(1);
        xfer(0, a_st, 0);
        check("cap as top", rd[0], 1'b0);
        pin(0);
        xfer(1, a_ca, 2);
        xfer(1, a_st, 1);
        pin(1);
        xfer(0, a_st, 0);
        check("cap as top", rd[0], 1'b0);
        // Mid-run reset must restore control B and clear the counter
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        xfer(0, a_cb, 0);
        check("ctrl_b rerun", rd, 32'h0);
        check("count rerun", {16'h0, count}, 32'h0);
        final_report;
    end
endmodule : tmc_timer_test
